//--- hw/pwm_out_b_deadband.sv
// Purpose : Second-output action logic and dead-band generator for two units
// Assumes : Event pulses come from the counter and comparators, one cycle each
// Notes   : Summary of operation below
//
// Summary of operation
// - Down mode: up compare events never occur
// - Zero or load beats any compare
// - Compare B beats compare A
// - Bits 11:10: compare B down action
// - Bits 9:8: compare B up, up/down only
// - Bits 7:6: compare A down action
// - Bits 5:4: compare A up, up/down only
// - Bits 3:2: load event action
// - Bits 1:0: zero event action
// - Disabled: A to out0, B to out1
// - Enabled: out0 is A, rise delayed
// - Enabled: out1 is A, fall delayed
// - Control bit 0 enables, resets clear
// - Rise delay: 12-bit tick count
// - Fall delay: 12-bit tick count
// - Rise delay swallows short high pulses
// - Fall delay swallows short low pulses
// - Unit 1 drives outputs 2 and 3
// - Reserved bits read zero, writes ignored
// - Codes: keep, invert, low, high
// - Compare above load never matches
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

module pwm_out_b_deadband #(
	parameter int UNITS = 2
) (
	input  wire logic                    i_clock,
	input  wire logic                    i_srst,
	input  wire logic [11:0]             i_addr,
	input  wire logic [31:0]             i_wr_data,
	input  wire logic                    i_wr_stb,
	input  wire logic                    i_rd_stb,
	output logic      [31:0]             o_rd_data,
	input  pwm_db_pkg::unit_events_s     i_events [UNITS],
	input  wire logic [UNITS-1:0]        i_first_action,
	output logic      [UNITS-1:0]        o_second_action,
	output logic      [2*UNITS-1:0]      o_deadband
);

	// ==========================================================
	// Helpers
	function automatic logic apply_action(input logic cur, input logic [1:0] code);
		logic res;
		res = cur;
		case (code)
			pwm_db_pkg::ACT_NONE:   res = cur;
			pwm_db_pkg::ACT_INVERT: res = ~cur;
			pwm_db_pkg::ACT_LOW:    res = 1'b0;
			pwm_db_pkg::ACT_HIGH:   res = 1'b1;
			default:                res = cur;
		endcase
		return res;
	endfunction

	function automatic logic [1:0] field(input logic [pwm_db_pkg::ACT_W-1:0] act, input int lsb);
		return act[lsb +: 2];
	endfunction

	// Unit u owns one register of each kind, at a fixed offset per unit
	function automatic logic unit_hit(input logic [11:0] addr, input int u,
		input logic [11:0] off0, input logic [11:0] off1);
		logic hit;
		hit = 1'b0;
		case (u)
			0:       hit = (addr == off0);
			1:       hit = (addr == off1);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// ==========================================================
	// Registers
	logic [pwm_db_pkg::ACT_W-1:0]   act_q  [UNITS];
	logic                           en_q   [UNITS];
	logic [pwm_db_pkg::DELAY_W-1:0] rise_q [UNITS];
	logic [pwm_db_pkg::DELAY_W-1:0] fall_q [UNITS];
	logic [31:0]                    rd_q;

	// Each setting has its own process so a decode slip stays local
	always_ff @(posedge i_clock)
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			if (i_srst)
			begin
				act_q[u] <= pwm_db_pkg::ACT_RESET;
			end
			else if (i_wr_stb && unit_hit(i_addr, u, pwm_db_pkg::OFF_GEN0_OUT_B,
				pwm_db_pkg::OFF_GEN1_OUT_B))
			begin
				// Only the defined fields are stored; reserved bits are dropped
				act_q[u] <= i_wr_data[pwm_db_pkg::ACT_W-1:0];
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			if (i_srst)
			begin
				en_q[u] <= pwm_db_pkg::DB_EN_RESET;
			end
			else if (i_wr_stb && unit_hit(i_addr, u, pwm_db_pkg::OFF_DB0_CONTROL,
				pwm_db_pkg::OFF_DB1_CONTROL))
			begin
				en_q[u] <= i_wr_data[pwm_db_pkg::DB_ENABLE_BIT];
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			if (i_srst)
			begin
				rise_q[u] <= pwm_db_pkg::DELAY_RESET;
			end
			else if (i_wr_stb && unit_hit(i_addr, u, pwm_db_pkg::OFF_DB0_RISE,
				pwm_db_pkg::OFF_DB1_RISE))
			begin
				rise_q[u] <= i_wr_data[pwm_db_pkg::DELAY_W-1:0];
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			if (i_srst)
			begin
				fall_q[u] <= pwm_db_pkg::DELAY_RESET;
			end
			else if (i_wr_stb && unit_hit(i_addr, u, pwm_db_pkg::OFF_DB0_FALL,
				pwm_db_pkg::OFF_DB1_FALL))
			begin
				fall_q[u] <= i_wr_data[pwm_db_pkg::DELAY_W-1:0];
			end
		end
	end

	// ==========================================================
	// Read port, data valid the cycle after the strobe only
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			rd_q <= pwm_db_pkg::RD_ZERO;
		end
		else if (i_rd_stb)
		begin
			rd_q <= pwm_db_pkg::RD_ZERO;
			case (i_addr)
				pwm_db_pkg::OFF_GEN0_OUT_B:  rd_q[pwm_db_pkg::ACT_W-1:0]   <= act_q[0];
				pwm_db_pkg::OFF_DB0_CONTROL: rd_q[pwm_db_pkg::DB_ENABLE_BIT] <= en_q[0];
				pwm_db_pkg::OFF_DB0_RISE:    rd_q[pwm_db_pkg::DELAY_W-1:0] <= rise_q[0];
				pwm_db_pkg::OFF_DB0_FALL:    rd_q[pwm_db_pkg::DELAY_W-1:0] <= fall_q[0];
				pwm_db_pkg::OFF_GEN1_OUT_B:  rd_q[pwm_db_pkg::ACT_W-1:0]   <= act_q[1];
				pwm_db_pkg::OFF_DB1_CONTROL: rd_q[pwm_db_pkg::DB_ENABLE_BIT] <= en_q[1];
				pwm_db_pkg::OFF_DB1_RISE:    rd_q[pwm_db_pkg::DELAY_W-1:0] <= rise_q[1];
				pwm_db_pkg::OFF_DB1_FALL:    rd_q[pwm_db_pkg::DELAY_W-1:0] <= fall_q[1];
				pwm_db_pkg::OFF_STATUS:
				begin
					rd_q[pwm_db_pkg::STAT_DB_LSB +: 2*UNITS]  <= o_deadband;
					rd_q[pwm_db_pkg::STAT_OUT_B_LSB +: UNITS] <= o_second_action;
				end
				default: ;
			endcase
		end
		else
		begin
			rd_q <= pwm_db_pkg::RD_ZERO;
		end
	end

	assign o_rd_data = rd_q;

	// ==========================================================
	// Second-output action logic
	logic [UNITS-1:0] out_b_q;
	logic [UNITS-1:0] out_b_d;

	always_comb
	begin
		logic       cmp_a_ok;
		logic       cmp_b_ok;
		logic [1:0] code;
		cmp_a_ok = 1'b0;
		cmp_b_ok = 1'b0;
		code     = pwm_db_pkg::ACT_NONE;
		for (int u = 0; u < UNITS; u++)
		begin
			// A comparator set above the load value never fires
			cmp_a_ok = i_events[u].cmp_a
				&& (i_events[u].cmp_a_value <= i_events[u].load_value);
			cmp_b_ok = i_events[u].cmp_b
				&& (i_events[u].cmp_b_value <= i_events[u].load_value);
			// Up-count compare events exist only in up/down mode
			if (!i_events[u].count_down && !i_events[u].mode_updown)
			begin
				cmp_a_ok = 1'b0;
				cmp_b_ok = 1'b0;
			end
			if (i_events[u].zero)
				code = field(act_q[u], pwm_db_pkg::ACT_ZERO_LSB);
			else if (i_events[u].load)
				code = field(act_q[u], pwm_db_pkg::ACT_LOAD_LSB);
			else if (cmp_b_ok)
				code = i_events[u].count_down
					? field(act_q[u], pwm_db_pkg::ACT_CMP_B_D_LSB)
					: field(act_q[u], pwm_db_pkg::ACT_CMP_B_U_LSB);
			else if (cmp_a_ok)
				code = i_events[u].count_down
					? field(act_q[u], pwm_db_pkg::ACT_CMP_A_D_LSB)
					: field(act_q[u], pwm_db_pkg::ACT_CMP_A_U_LSB);
			else
				code = pwm_db_pkg::ACT_NONE;
			out_b_d[u] = apply_action(out_b_q[u], code);
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			out_b_q <= '0;
		end
		else
		begin
			out_b_q <= out_b_d;
		end
	end

	assign o_second_action = out_b_q;

	// ==========================================================
	// Dead-band generator
	// Counters track how long the first output has been high or low,
	// saturating so that a full-scale delay still holds off the edge
	localparam logic [pwm_db_pkg::DELAY_W-1:0] CNT_MAX = '1;

	logic [pwm_db_pkg::DELAY_W-1:0] high_cnt_q [UNITS];
	logic [pwm_db_pkg::DELAY_W-1:0] low_cnt_q  [UNITS];
	logic [UNITS-1:0]               lead_q;
	logic [UNITS-1:0]               trail_q;
	logic [2*UNITS-1:0]             db_w;

	always_ff @(posedge i_clock)
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			if (i_srst)
			begin
				high_cnt_q[u] <= '0;
			end
			else if (!i_first_action[u])
			begin
				high_cnt_q[u] <= '0;
			end
			else if (high_cnt_q[u] != CNT_MAX)
			begin
				high_cnt_q[u] <= high_cnt_q[u] + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			if (i_srst)
			begin
				low_cnt_q[u] <= '0;
			end
			else if (i_first_action[u])
			begin
				low_cnt_q[u] <= '0;
			end
			else if (low_cnt_q[u] != CNT_MAX)
			begin
				low_cnt_q[u] <= low_cnt_q[u] + 1'b1;
			end
		end
	end

	// Lead output: rising edge held back by the rise delay
	always_ff @(posedge i_clock)
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			if (i_srst)
			begin
				lead_q[u] <= 1'b0;
			end
			else if (en_q[u])
			begin
				// A high pulse no longer than the delay never shows
				lead_q[u] <= i_first_action[u]
					&& (high_cnt_q[u] >= rise_q[u]);
			end
			else
			begin
				// Delay settings are not looked at while disabled
				lead_q[u] <= i_first_action[u];
			end
		end
	end

	// Trail output: falling edge held back by the fall delay
	always_ff @(posedge i_clock)
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			if (i_srst)
			begin
				trail_q[u] <= 1'b0;
			end
			else if (en_q[u])
			begin
				// A low pulse no longer than the delay never shows
				trail_q[u] <= i_first_action[u]
					|| (low_cnt_q[u] < fall_q[u]);
			end
			else
			begin
				// Second action output passes only while disabled
				trail_q[u] <= out_b_q[u];
			end
		end
	end

	// Outputs pair up per unit: lead on the even bit, trail on the odd one
	always_comb
	begin
		for (int u = 0; u < UNITS; u++)
		begin
			db_w[2*u]   = lead_q[u];
			db_w[2*u+1] = trail_q[u];
		end
	end

	assign o_deadband = db_w;

endmodule

//--- pkg/pwm_db_pkg.sv
// Purpose : Shared constants and types for the second-output action and dead-band block
// Assumes : Register offsets are byte addresses on a 12-bit register port
// Notes   : Reserved register bits read as zero
package pwm_db_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFF_GEN0_OUT_B  = 12'h064;
	localparam logic [11:0] OFF_DB0_CONTROL = 12'h068;
	localparam logic [11:0] OFF_DB0_RISE    = 12'h06C;
	localparam logic [11:0] OFF_DB0_FALL    = 12'h070;
	localparam logic [11:0] OFF_GEN1_OUT_B  = 12'h0A4;
	localparam logic [11:0] OFF_DB1_CONTROL = 12'h0A8;
	localparam logic [11:0] OFF_DB1_RISE    = 12'h0AC;
	localparam logic [11:0] OFF_DB1_FALL    = 12'h0B0;
	localparam logic [11:0] OFF_STATUS      = 12'h0C0;

	// ==========================================================
	// Field layout
	localparam int ACT_ZERO_LSB    = 0;
	localparam int ACT_LOAD_LSB    = 2;
	localparam int ACT_CMP_A_U_LSB = 4;
	localparam int ACT_CMP_A_D_LSB = 6;
	localparam int ACT_CMP_B_U_LSB = 8;
	localparam int ACT_CMP_B_D_LSB = 10;
	localparam int ACT_W           = 12;
	localparam int DB_ENABLE_BIT   = 0;
	localparam int DELAY_W         = 12;
	localparam int STAT_DB_LSB     = 0;
	localparam int STAT_OUT_B_LSB  = 4;

	// ==========================================================
	// Reset values
	localparam logic [ACT_W-1:0]   ACT_RESET   = 12'h000;
	localparam logic [DELAY_W-1:0] DELAY_RESET = 12'h000;
	localparam logic               DB_EN_RESET = 1'b0;
	localparam logic [31:0]        RD_ZERO     = 32'h0000_0000;

	// ==========================================================
	// Action codes
	typedef enum logic [1:0]
	{
		ACT_NONE   = 2'h0,
		ACT_INVERT = 2'h1,
		ACT_LOW    = 2'h2,
		ACT_HIGH   = 2'h3
	} action_e;

	// ==========================================================
	// Counter and comparator events of one generator unit
	typedef struct packed
	{
		logic        zero;
		logic        load;
		logic        cmp_a;
		logic        cmp_b;
		logic        count_down;
		logic        mode_updown;
		logic [15:0] load_value;
		logic [15:0] cmp_a_value;
		logic [15:0] cmp_b_value;
	} unit_events_s;

endpackage

//--- verif/pwm_db_properties.sv
// Purpose: Port checker for the action and dead-band block
// Assumes: Shadow settings follow bus writes at the same edge
// Notes  : Watches unit 0; unit 1 is left to the bench
`timescale 1ns/1ps

module pwm_db_properties #(
	parameter int UNITS = 2
) (
	input  wire logic                 i_clock,
	input  wire logic                 i_srst,
	input  wire logic [11:0]          i_addr,
	input  wire logic [31:0]          i_wr_data,
	input  wire logic                 i_wr_stb,
	input  wire logic                 i_rd_stb,
	input  wire logic [31:0]          o_rd_data,
	input  pwm_db_pkg::unit_events_s  i_events [UNITS],
	input  wire logic [UNITS-1:0]     i_first_action,
	input  wire logic [UNITS-1:0]     o_second_action,
	input  wire logic [2*UNITS-1:0]   o_deadband
);
	logic [1:0]  zact_q;
	logic        en_q;
	logic [11:0] rise_q;

	// ====
	// Shadow settings, unit 0
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			zact_q <= 2'h0;
			en_q   <= 1'b0;
			rise_q <= 12'h000;
		end
		else if (i_wr_stb)
		begin
			if (i_addr == pwm_db_pkg::OFF_GEN0_OUT_B) zact_q <= i_wr_data[1:0];
			if (i_addr == pwm_db_pkg::OFF_DB0_CONTROL) en_q <= i_wr_data[0];
			if (i_addr == pwm_db_pkg::OFF_DB0_RISE) rise_q <= i_wr_data[11:0];
		end
	end

	// ====
	// Properties
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	property p_rd_idle; !$past(i_rd_stb) |-> o_rd_data == 32'h0000_0000; endproperty
	property p_zero_high; i_events[0].zero && zact_q == 2'h3 |=> o_second_action[0]; endproperty
	property p_zero_keep; i_events[0].zero && zact_q == 2'h0 |=> $stable(o_second_action[0]);
	endproperty
	property p_zero_inv; i_events[0].zero && zact_q == 2'h1
		|=> o_second_action[0] != $past(o_second_action[0]); endproperty
	property p_pass_a; !en_q |=> o_deadband[0] == $past(i_first_action[0]); endproperty
	property p_pass_b; !en_q |=> o_deadband[1] == $past(o_second_action[0]); endproperty
	property p_fall_fast; en_q && !i_first_action[0] |=> !o_deadband[0]; endproperty
	property p_rise_delay; en_q && rise_q == 12'h002 && $rose(i_first_action[0])
		##1 (en_q && i_first_action[0]) [*2] |-> !o_deadband[0] ##1 o_deadband[0]; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_zero_high: assert property (p_zero_high) else $error("zero high lost");
	a_zero_keep: assert property (p_zero_keep) else $error("compare beat zero");
	a_zero_inv: assert property (p_zero_inv) else $error("toggle lost");
	a_pass_a: assert property (p_pass_a) else $error("out0 not passed");
	a_pass_b: assert property (p_pass_b) else $error("out1 not passed");
	a_fall_fast: assert property (p_fall_fast) else $error("out0 fall late");
	a_rise_delay: assert property (p_rise_delay) else $error("rise delay off");
	c_zero_high: cover property (i_events[0].zero && zact_q == 2'h3);
	c_rise: cover property (en_q ##1 $rose(o_deadband[0]));
	c_read: cover property (i_rd_stb ##1 o_rd_data != 32'h0000_0000);
endmodule

//--- verif/pwm_stage_model.sv
// Purpose: Power stage driven by the dead-band outputs
// Assumes: Gates are sampled on the system clock
// Notes  : Counts turn-on edges of the unit 0 high side
`timescale 1ns/1ps

module pwm_stage_model (
	input  wire logic       i_clock,
	input  wire logic [3:0] i_gate,
	output int              o_rises
);
	logic last_q = 1'b0;

	// ====
	// Turn-on counter
	always @(posedge i_clock)
	begin
		if (i_gate[0] && !last_q) o_rises <= o_rises + 1;
		last_q <= i_gate[0];
	end
endmodule

//--- verif/pwm_out_b_deadband_test.sv
// Purpose: Self-checking bench for the action and dead-band block
// Assumes: Registered outputs are read just after the clock edge
// Notes  : Random stimulus from a fixed xorshift seed
`timescale 1ns/1ps

module pwm_out_b_deadband_test;
	logic                     i_clock   = 1'b0;
	logic                     i_srst    = 1'b1;
	logic [11:0]              i_addr    = 12'h000;
	logic [31:0]              i_wr_data = 32'h0000_0000;
	logic                     i_wr_stb  = 1'b0;
	logic                     i_rd_stb  = 1'b0;
	logic [31:0]              o_rd_data;
	pwm_db_pkg::unit_events_s i_events [2] = '{default: '0};
	logic [1:0]               i_first_action = 2'h0;
	logic [1:0]               o_second_action;
	logic [3:0]               o_deadband;
	pwm_db_pkg::unit_events_s ev;
	int err_total = 0, compares = 0, rises, n, nr = 0, x = 45926, r;
	int hi [2], lo [2] = '{4095, 4095}, rd [2] = '{2, 1}, fd [2] = '{3, 4}, run [2] = '{0, 0};
	logic [11:0] act [2], a;
	logic [1:0]  eb = 2'h0, ob, fa = 2'h0;
	logic [3:0]  e1 = 4'h0, e2 = 4'h0;

	always #20 i_clock = ~i_clock;
	pwm_out_b_deadband #(.UNITS(2)) dut (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
		.i_events(i_events), .i_first_action(i_first_action),
		.o_second_action(o_second_action), .o_deadband(o_deadband));
	pwm_stage_model stage (.i_clock(i_clock), .i_gate(o_deadband), .o_rises(rises));

	function automatic int rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x & 32'h7FFF_FFFF;
	endfunction

	// Codes 2 and 3 force the low bit of the code
	function automatic logic nb(input logic c, input logic [11:0] s,
		input pwm_db_pkg::unit_events_s e);
		int f;
		f = e.zero ? 0 : e.load ? 2 : -1;
		if (f < 0 && e.cmp_b && e.cmp_b_value <= e.load_value && (e.count_down || e.mode_updown))
			f = e.count_down ? 10 : 8;
		if (f < 0 && e.cmp_a && e.cmp_a_value <= e.load_value && (e.count_down || e.mode_updown))
			f = e.count_down ? 6 : 4;
		return (f < 0 || s[f+:2] == 2'h0) ? c : (s[f+:2] == 2'h1) ? !c : s[f];
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		@(posedge i_clock);
		i_addr    <= ad;
		i_wr_data <= d;
		i_wr_stb  <= 1'b1;
		@(posedge i_clock);
		i_wr_stb  <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] ad, input logic [31:0] e);
		@(posedge i_clock);
		i_addr   <= ad;
		i_rd_stb <= 1'b1;
		@(posedge i_clock);
		i_rd_stb <= 1'b0;
		@(posedge i_clock);
		chk("rd_data", e, o_rd_data);
	endtask

	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ====
	// Main sequence
	initial
	begin
		repeat (16) @(posedge i_clock);
		i_srst <= 1'b0;
		rdc(pwm_db_pkg::OFF_STATUS, 0);
		for (int j = 0; j < 8; j++)
		begin
			a = 12'((j < 4 ? pwm_db_pkg::OFF_GEN0_OUT_B : pwm_db_pkg::OFF_GEN1_OUT_B) + 4 * (j % 4));
			rdc(a, 0);
			r = rnd();
			wr(a, r);
			rdc(a, r & (j % 4 == 1 ? 1 : 32'hFFF));
		end
		wr(12'h0F0, 32'hFFFF_FFFF);
		rdc(12'h0F0, 0);
		$display("registers done");
		for (int j = 0; j < 6; j++)
			wr(pwm_db_pkg::OFF_DB0_CONTROL + 12'h040 * (j / 3) + 4 * ((j + 1) % 3),
				j % 3 == 2 ? 1 : (j % 3 == 0 ? rd[j / 3] : fd[j / 3]));
		n = rises;
		for (int i = 0; i < 600; i++)
		begin
			@(posedge i_clock);
			chk("deadband", e2, o_deadband);
			e2 = e1;
			for (int u = 0; u < 2; u++)
			begin
				if (run[u] == 0)
				begin
					fa[u] = !fa[u];
					run[u] = 1 + rnd() % 7;
				end
				run[u]--;
				hi[u] = fa[u] ? hi[u] + 1 : 0;
				lo[u] = fa[u] ? 0 : lo[u] + 1;
				e1[2*u] = hi[u] > rd[u];
				e1[2*u+1] = lo[u] <= fd[u];
			end
			nr += e1[0] && !e2[0];
			i_first_action <= fa;
		end
		repeat (3) @(posedge i_clock);
		chk("rises", nr, rises - n);
		fa = 2'h0;
		i_first_action <= fa;
		wr(pwm_db_pkg::OFF_DB0_CONTROL, 0);
		wr(pwm_db_pkg::OFF_DB1_CONTROL, 0);
		e1 = 4'h0;
		$display("deadband done");
		for (int i = 0; i < 400; i++)
		begin
			if (i % 50 == 0)
			begin
				for (int u = 0; u < 2; u++)
				begin
					act[u] = 12'(rnd());
					wr(u ? pwm_db_pkg::OFF_GEN1_OUT_B : pwm_db_pkg::OFF_GEN0_OUT_B, act[u]);
				end
				e1 = {eb[1], fa[1], eb[0], fa[0]};
			end
			@(posedge i_clock);
			chk("second", eb, o_second_action);
			chk("passthru", e1, o_deadband);
			ob = eb;
			for (int u = 0; u < 2; u++)
			begin
				r = rnd();
				ev = {r[0] & r[1], r[2] & r[3], r[4], r[5], r[6], r[7],
					12'h000, r[11:8], 12'h000, r[15:12], 12'h000, r[19:16]};
				i_events[u] <= ev;
				eb[u] = nb(eb[u], act[u], ev);
			end
			fa = 2'(rnd());
			i_first_action <= fa;
			e1 = {ob[1], fa[1], ob[0], fa[0]};
			@(posedge i_clock);
			i_events <= '{default: '0};
		end
		$display("actions done");
		complete_run();
	end
endmodule

bind pwm_out_b_deadband pwm_db_properties #(.UNITS(UNITS)) chk_u (.i_clock(i_clock),
	.i_srst(i_srst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb),
	.i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_events(i_events),
	.i_first_action(i_first_action), .o_second_action(o_second_action), .o_deadband(o_deadband));
